// File: rtl/cmoc_consts.svh
// Purpose: constants for the conversion mode and offset control block
// Assumes: 8-bit register port from the serial engine, 250 MHz clock
// Notes: offsets are the register addresses as the host sees them
`ifndef CMOC_CONSTS_SVH
`define CMOC_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses and reset values
// ----------------------------------------------------------------
`define CMOC_ADDR_TIMEOUT 8'h10
`define CMOC_ADDR_OFFSET1 8'h11
`define CMOC_ADDR_OFFSET2 8'h12
`define CMOC_RST_TIMEOUT 8'h00
`define CMOC_RST_OFFSET 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMOC_OFS_EN_BIT 7
`define CMOC_OFS_TRK_BIT 6
`define CMOC_CODE_MAX 6'h3F

// ----------------------------------------------------------------
// timing: one timeout step is four hours
// ----------------------------------------------------------------
`define CMOC_STEP_HOURS 4
`define CMOC_CLK_MHZ 250
`define CMOC_STEP_CYCLES (64'd4 * 64'd3600 * 64'd250 * 64'd1000000)

`endif

// File: rtl/cmoc_inact_timer.sv
// Purpose: inactivity timer that requests automatic power-down
// Assumes: step count parameter may be shortened for simulation
// Notes: expiry is a one-cycle pulse
`timescale 1ns/10ps
`include "cmoc_consts.svh"
module cmoc_inact_timer import cmoc_pkg::*; #(
	parameter logic [63:0] STEP_CYCLES = `CMOC_STEP_CYCLES
) (
	input wire logic clk_in, // core clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic ce_in, // clock enable
	input wire logic [5:0] timeout_in, // six-bit timeout field
	input wire logic restart_in, // restart the period
	input wire logic run_in, // count only while not powered down
	output logic expire_out // one-cycle expiry pulse
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [63:0] sub; // cycles within one step
		logic [5:0] steps; // whole steps elapsed
		logic expire;
	} cmoc_tmr_t;

	cmoc_tmr_t st;
	cmoc_tmr_t next_st;

	// counts steps of four hours; zero field disables
	always_comb begin
		next_st = st;
		next_st.expire = 1'b0;
		if (restart_in || timeout_in == 6'h00 || !run_in) begin // [RQ9] [RQ21]
			next_st.sub = 64'h0;
			next_st.steps = 6'h00;
		end else if (st.sub == STEP_CYCLES - 64'h1) begin // [RQ8]
			next_st.sub = 64'h0;
			if (st.steps + 6'h01 == timeout_in) begin // [RQ6]
				next_st.expire = 1'b1;
				next_st.steps = 6'h00;
			end else begin
				next_st.steps = st.steps + 6'h01;
			end
		end else begin
			next_st.sub = st.sub + 64'h1;
		end
	end

	// register the state
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign expire_out = st.expire;

	// a zero field must never expire
	timer_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(timeout_in == 6'h00) |=> !expire_out) else $error("timer expired while disabled"); // [RQ9]

endmodule : cmoc_inact_timer

// File: rtl/cmoc_mode_ctrl.sv
// Purpose: conversion mode decode, inactivity power-down, offset control
// Assumes: serial engine delivers decoded register writes and reads
// Notes: converter core, comparators and serial engine are outside
//
// Contract
// RQ1 - mode field: idle, continuous, single, power-down
// RQ2 - single mode converts each enabled channel once
// RQ3 - power-down turns off all but serial interface; code keeps offset tracking and trk_active_out running in power-down
// RQ4 - host never writes mode with top bit
// RQ5 - host keeps timeout bits seven, six zero
// RQ6 - inactivity period expiry forces power-down
// RQ7 - leave auto power-down only by command
// RQ8 - timeout counts four hours per step
// RQ9 - zero timeout disables the timer
// RQ10 - offset source on only when bit seven
// RQ11 - tracking when bit six and adaptive
// RQ12 - raise code when average above three quarters
// RQ13 - lower code when average below one quarter
// RQ14 - step size follows input range
// RQ15 - fixed threshold mode disables tracking
// RQ16 - six low bits are linear offset code
// RQ17 - separate offset register per channel
// RQ18 - threshold select one means fixed mode
// RQ19 - convert channel only when enabled
// RQ20 - single mode returns to idle after
// RQ21 - activity or timeout rewrite restarts period
`timescale 1ns/10ps
`include "cmoc_consts.svh"
module cmoc_mode_ctrl import cmoc_pkg::*; #(
	parameter int AVG_W = 12, // width of the data averages
	parameter logic [63:0] STEP_CYCLES = `CMOC_STEP_CYCLES // cycles per four hours
) (
	input wire logic clk_in, // core clock, 250 MHz
	input wire logic reset_n_in, // async reset, active low
	input wire logic ce_in, // clock enable, freezes state when low
	input wire cmoc_wr_t wr_in, // register write from serial engine
	input wire logic [7:0] raddr_in, // register read address
	output logic [7:0] rdata_out, // register read data
	output logic rhit_out, // read address belongs to this block
	input wire logic [2:0] op_mode_in, // op_mode_bit2..0 from setup register
	input wire logic mode_wr_in, // setup register written this cycle
	input wire logic fixed_threshold_select_in, // 1 fixed, 0 adaptive
	input wire logic channel_one_enable_in, // channel one enable
	input wire logic channel_two_enable_in, // channel two enable
	input wire logic [5:0] step_in, // tracking step from input range
	input wire logic [1:0] cmp_active_in, // comparator outputs
	input wire logic [1:0] avg_upd_in, // new average per channel
	input wire logic [AVG_W-1:0] avg1_in, // channel one average
	input wire logic [AVG_W-1:0] avg2_in, // channel two average
	input wire logic conv_done_in, // converter finished one conversion
	output logic conv_start_out, // start one conversion
	output logic conv_ch_out, // channel of that conversion, 0 = one
	output logic core_power_out, // analog power on
	output cmoc_mode_t mode_out, // effective mode
	output logic auto_pdown_out, // sitting in automatic power-down
	output logic [1:0] ofs_src_en_out, // offset source enable per channel
	output logic [1:0] trk_active_out, // tracking active per channel
	output logic [5:0] ofs_code1_out, // channel one offset code
	output logic [5:0] ofs_code2_out // channel two offset code
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum {
		CV_IDLE,
		CV_WAIT
	} cmoc_cv_t;

	typedef struct packed {
		logic [7:0] timeout; // timeout register
		logic auto_pd; // automatic power-down latched
		logic single_done; // single run finished, hold idle
		logic busy; // conversion in flight
		logic ch; // channel in flight
		logic second; // second channel still owed in single
		logic start; // start pulse
		logic [7:0] rdata; // read data
	} cmoc_st_t;

	cmoc_st_t st;
	cmoc_st_t next_st;
	cmoc_mode_t dec_mode;
	cmoc_mode_t eff_mode;
	cmoc_ofs_t ofs1;
	cmoc_ofs_t ofs2;
	logic wr_tmo;
	logic wr_o1;
	logic wr_o2;
	logic expire;
	logic adaptive;
	logic any_en;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------

	// reserved codes are the host's to avoid; treat as idle to stay safe
	always_comb begin
		case (op_mode_in) // [RQ1] [RQ4]
			3'h0: dec_mode = CMOC_MODE_IDLE;
			3'h1: dec_mode = CMOC_MODE_CONT;
			3'h2: dec_mode = CMOC_MODE_SINGLE;
			3'h3: dec_mode = CMOC_MODE_PDOWN;
			default: dec_mode = CMOC_MODE_IDLE;
		endcase
	end

	// auto power-down overrides the field until a new mode command
	always_comb begin
		if (st.auto_pd) begin
			eff_mode = CMOC_MODE_PDOWN; // [RQ7]
		end else if (dec_mode == CMOC_MODE_SINGLE && st.single_done) begin
			eff_mode = CMOC_MODE_IDLE; // [RQ20]
		end else begin
			eff_mode = dec_mode;
		end
	end

	assign adaptive = !fixed_threshold_select_in; // [RQ18]
	assign any_en = channel_one_enable_in || channel_two_enable_in;
	assign wr_tmo = wr_in.wr && wr_in.addr == `CMOC_ADDR_TIMEOUT;
	assign wr_o1 = wr_in.wr && wr_in.addr == `CMOC_ADDR_OFFSET1; // [RQ17]
	assign wr_o2 = wr_in.wr && wr_in.addr == `CMOC_ADDR_OFFSET2; // [RQ17]

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------

	// timer only runs while the part is awake
	cmoc_inact_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_timer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.timeout_in(st.timeout[5:0]), // [RQ5]
		.restart_in(wr_tmo || cmp_active_in != 2'b00), // [RQ21]
		.run_in(eff_mode != CMOC_MODE_PDOWN),
		.expire_out(expire)
	);

	cmoc_offset_track #(
		.AVG_W(AVG_W)
	) u_ofs1 (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.wr_in(wr_o1),
		.wdata_in(wr_in.data),
		.adaptive_in(adaptive),
		.avg_upd_in(avg_upd_in[0]),
		.avg_in(avg1_in),
		.step_in(step_in),
		.ofs_out(ofs1),
		.trk_active_out(trk_active_out[0])
	);

	cmoc_offset_track #(
		.AVG_W(AVG_W)
	) u_ofs2 (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.wr_in(wr_o2),
		.wdata_in(wr_in.data),
		.adaptive_in(adaptive),
		.avg_upd_in(avg_upd_in[1]),
		.avg_in(avg2_in),
		.step_in(step_in),
		.ofs_out(ofs2),
		.trk_active_out(trk_active_out[1])
	);

	// ----------------------------------------------------------------
	// sequencing and registers
	// ----------------------------------------------------------------

	// one conversion in flight at a time; single mode takes channel one first
	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		if (wr_tmo) begin
			next_st.timeout = wr_in.data;
		end
		// an expiry in the same cycle as a mode command wins, so it is never lost
		if (expire) begin
			next_st.auto_pd = 1'b1; // [RQ6]
		end else if (mode_wr_in) begin
			next_st.auto_pd = 1'b0; // [RQ7]
		end
		if (mode_wr_in) begin
			next_st.single_done = 1'b0;
			next_st.second = 1'b0;
		end
		if (st.busy) begin
			if (conv_done_in) begin
				next_st.busy = 1'b0;
				if (eff_mode == CMOC_MODE_SINGLE && !st.second && !mode_wr_in) begin
					next_st.single_done = 1'b1; // [RQ20]
				end
			end
		end else if (!mode_wr_in && any_en) begin
			case (eff_mode)
				CMOC_MODE_CONT: begin
					next_st.start = 1'b1;
					next_st.busy = 1'b1;
					// alternate when both are on, else the lone one
					next_st.ch = (channel_one_enable_in && channel_two_enable_in) ? !st.ch
						: !channel_one_enable_in; // [RQ19]
				end
				CMOC_MODE_SINGLE: begin
					next_st.start = 1'b1;
					next_st.busy = 1'b1;
					if (st.second) begin
						next_st.ch = 1'b1;
						next_st.second = 1'b0;
					end else begin
						next_st.ch = !channel_one_enable_in; // [RQ19]
						next_st.second = channel_one_enable_in && channel_two_enable_in; // [RQ2]
					end
				end
				default: begin
					next_st.busy = 1'b0;
				end
			endcase
		end
		case (raddr_in)
			`CMOC_ADDR_TIMEOUT: next_st.rdata = st.timeout;
			`CMOC_ADDR_OFFSET1: next_st.rdata = ofs1;
			`CMOC_ADDR_OFFSET2: next_st.rdata = ofs2;
			default: next_st.rdata = 8'h00;
		endcase
	end

	// register the state
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
			st.timeout <= `CMOC_RST_TIMEOUT;
			st.ch <= 1'b1; // first continuous start lands on channel one
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_out = st.rdata;
	assign rhit_out = raddr_in inside {`CMOC_ADDR_TIMEOUT, `CMOC_ADDR_OFFSET1,
		`CMOC_ADDR_OFFSET2};
	assign conv_start_out = st.start;
	assign conv_ch_out = st.ch;
	assign mode_out = eff_mode;
	assign auto_pdown_out = st.auto_pd;
	assign core_power_out = eff_mode != CMOC_MODE_PDOWN; // [RQ3]
	assign ofs_src_en_out = {ofs2.src_en, ofs1.src_en} & {2{core_power_out}}; // [RQ10]
	assign ofs_code1_out = ofs1.code; // [RQ16]
	assign ofs_code2_out = ofs2.code;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	pdown_power_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(mode_out == CMOC_MODE_PDOWN) |-> !core_power_out && !conv_start_out) // [RQ3]
		else $error("power on in power-down");

	auto_pd_sets_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && expire) |=> auto_pdown_out) else $error("no auto pd"); // [RQ6]

	auto_pd_holds_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(auto_pdown_out && !mode_wr_in) |=> auto_pdown_out) else $error("left auto pd"); // [RQ7]

	chan_enable_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		conv_start_out |-> (conv_ch_out ? $past(channel_two_enable_in)
		: $past(channel_one_enable_in))) else $error("disabled channel"); // [RQ19]

	src_enable_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ofs_src_en_out[0] |-> ofs1.src_en) else $error("source on without bit"); // [RQ10]

	single_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(st.single_done && !mode_wr_in) |=> !conv_start_out) else $error("extra single"); // [RQ20]

endmodule : cmoc_mode_ctrl

// File: rtl/cmoc_offset_track.sv
// Purpose: per-channel offset register with automatic tracking
// Assumes: average update strobe comes once per new average
// Notes: step size follows the selected input range
`timescale 1ns/10ps
`include "cmoc_consts.svh"
module cmoc_offset_track import cmoc_pkg::*; #(
	parameter int AVG_W = 12 // width of the data average
) (
	input wire logic clk_in, // core clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic ce_in, // clock enable
	input wire logic wr_in, // host write to this register
	input wire logic [7:0] wdata_in, // host write data
	input wire logic adaptive_in, // adaptive threshold mode active
	input wire logic avg_upd_in, // new average available
	input wire logic [AVG_W-1:0] avg_in, // channel data average
	input wire logic [5:0] step_in, // step size from input range
	output cmoc_ofs_t ofs_out, // register contents
	output logic trk_active_out // tracking currently on
);

	// ----------------------------------------------------------------
	// state and thresholds
	// ----------------------------------------------------------------
	localparam logic [AVG_W-1:0] HI_LIM = AVG_W'((3 * (2 ** AVG_W)) / 4); // three quarters
	localparam logic [AVG_W-1:0] LO_LIM = AVG_W'((2 ** AVG_W) / 4); // one quarter

	cmoc_ofs_t st;
	cmoc_ofs_t next_st;
	logic trk;

	// tracking only in adaptive mode with the bit set
	assign trk = st.trk_en && adaptive_in; // [RQ11] [RQ15]

	// host write wins; otherwise saturating steps up or down
	always_comb begin
		next_st = st;
		if (wr_in) begin
			next_st = cmoc_ofs_t'(wdata_in); // [RQ16]
		end else if (trk && avg_upd_in) begin
			if (avg_in > HI_LIM) begin // [RQ12] [RQ14]
				next_st.code = (st.code > `CMOC_CODE_MAX - step_in) ? `CMOC_CODE_MAX
					: st.code + step_in;
			end else if (avg_in < LO_LIM) begin // [RQ13] [RQ14]
				next_st.code = (st.code < step_in) ? 6'h00 : st.code - step_in;
			end
		end
	end

	// register the state
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= cmoc_ofs_t'(`CMOC_RST_OFFSET);
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign ofs_out = st;
	assign trk_active_out = trk;

	// fixed mode never moves the code on its own
	fixed_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && !wr_in && !adaptive_in) |=> $stable(st.code)) else $error("code moved"); // [RQ15]

	// high average with room raises the code
	raise_code_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && !wr_in && trk && avg_upd_in && avg_in > HI_LIM && step_in != 6'h00
		&& st.code != `CMOC_CODE_MAX) |=> st.code > $past(st.code)) else $error("no raise"); // [RQ12]

	// low average with room lowers the code
	lower_code_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && !wr_in && trk && avg_upd_in && avg_in < LO_LIM && step_in != 6'h00
		&& st.code != 6'h00) |=> st.code < $past(st.code)) else $error("no lower"); // [RQ13]

endmodule : cmoc_offset_track

// File: rtl/cmoc_pkg.sv
// Purpose: shared types for the conversion mode and offset control block
// Assumes: used together with cmoc_consts.svh
// Notes: types only; numbers live in the header
package cmoc_pkg;

	// decoded operating mode
	typedef enum logic [1:0] {
		CMOC_MODE_IDLE,
		CMOC_MODE_CONT,
		CMOC_MODE_SINGLE,
		CMOC_MODE_PDOWN
	} cmoc_mode_t;

	// register write strobe with address and data
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} cmoc_wr_t;

	// one channel's offset register
	typedef struct packed {
		logic src_en;
		logic trk_en;
		logic [5:0] code;
	} cmoc_ofs_t;

endpackage : cmoc_pkg

// File: verification/cmoc_host_model.sv
// Purpose: host model that writes and reads the block's registers
// Assumes: tasks are called just after a rising clock edge
// Notes: idle bus lines show inverted data so stale values cannot pass
`timescale 1ns/10ps
`include "cmoc_consts.svh"
module cmoc_host_model import cmoc_pkg::*; (
	input wire logic clk_in, // core clock
	output cmoc_wr_t wr_out, // register write strobe
	output logic [7:0] raddr_out, // read address
	output logic rd_out, // read request marker for the bench
	output logic [2:0] op_mode_out, // mode field
	output logic mode_wr_out // mode field written
);
	// ----------------------------------------
	// bus idle at time zero
	// ----------------------------------------
	initial begin
		wr_out = '0;
		raddr_out = 8'hEE;
		rd_out = 1'b0;
		op_mode_out = 3'h0;
		mode_wr_out = 1'b0;
	end

	// one write then an idle cycle, so a strobe never toggles twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		if (a == `CMOC_ADDR_TIMEOUT) d[7:6] = 2'h0; // upper timeout bits kept clear
		wr_out = '{1'b1, a, d};
		@(posedge clk_in);
		#1 wr_out = '{1'b0, ~a, ~d};
		@(posedge clk_in);
		#1;
	endtask : wr_reg

	// read address held for one edge; data lands one edge later
	task automatic rd_reg(input logic [7:0] a);
		raddr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1 raddr_out = ~a;
		rd_out = 1'b0;
		@(posedge clk_in);
		#1;
	endtask : rd_reg

	// mode write; reserved codes with the top bit are never sent
	task automatic set_mode(input logic [2:0] op);
		op_mode_out = {1'b0, op[1:0]};
		mode_wr_out = 1'b1;
		@(posedge clk_in);
		#1 mode_wr_out = 1'b0;
		@(posedge clk_in);
		#1;
	endtask : set_mode
endmodule : cmoc_host_model

// File: verification/cmoc_mode_ctrl_bench.sv
// Purpose: self-checking bench for the mode and offset control block
// Assumes: timeout step shortened to 4 cycles, 12-bit averages
// Notes: reads and conversion starts are checked from expectation queues
`timescale 1ns/10ps
module cmoc_mode_ctrl_bench import cmoc_pkg::*; ;
	logic clk = 1'b0; // core clock
	logic reset_n = 1'b0; // async reset, active low
	logic ce = 1'b1; // clock enable, dropped once per channel to check the freeze
	cmoc_wr_t wr; // host write
	logic [7:0] raddr; // host read address
	logic [7:0] rdata; // read data
	logic rd_mark; // host read marker
	logic rd_d = 1'b0; // read marker one edge later
	logic rhit; // read hit
	logic [2:0] op_mode; // mode field
	logic mode_wr; // mode written
	logic fixed_sel = 1'b0; // threshold select
	logic en1 = 1'b0; // channel one enable
	logic en2 = 1'b0; // channel two enable
	logic [5:0] step = 6'h01; // tracking step
	logic [1:0] cmp = 2'b00; // comparator outputs
	logic [1:0] avg_upd = 2'b00; // average strobes
	logic [11:0] avg1 = 12'h000; // channel one average
	logic [11:0] avg2 = 12'h000; // channel two average
	logic conv_done = 1'b0; // converter finished
	logic conv_start, conv_ch, core_power, auto_pd;
	cmoc_mode_t mode;
	logic [1:0] src_en, trk_act;
	logic [5:0] code1, code2;
	logic [31:0] seed = 32'h97F6; // xorshift state
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] exp_rd[$]; // expected read data
	logic exp_ch[$]; // expected conversion channels

	initial forever #2 clk = ~clk;

	cmoc_host_model u_cmoc_host_model (.clk_in(clk), .wr_out(wr), .raddr_out(raddr),
		.rd_out(rd_mark), .op_mode_out(op_mode), .mode_wr_out(mode_wr));

	cmoc_mode_ctrl #(.AVG_W(12), .STEP_CYCLES(64'd4)) u_cmoc_mode_ctrl (
		.clk_in(clk), .reset_n_in(reset_n), .ce_in(ce), .wr_in(wr), .raddr_in(raddr),
		.rdata_out(rdata), .rhit_out(rhit), .op_mode_in(op_mode), .mode_wr_in(mode_wr),
		.fixed_threshold_select_in(fixed_sel), .channel_one_enable_in(en1),
		.channel_two_enable_in(en2), .step_in(step), .cmp_active_in(cmp),
		.avg_upd_in(avg_upd), .avg1_in(avg1), .avg2_in(avg2), .conv_done_in(conv_done),
		.conv_start_out(conv_start), .conv_ch_out(conv_ch), .core_power_out(core_power),
		.mode_out(mode), .auto_pdown_out(auto_pd), .ofs_src_en_out(src_en),
		.trk_active_out(trk_act), .ofs_code1_out(code1), .ofs_code2_out(code2));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		u_cmoc_host_model.rd_reg(a);
	endtask : rd

	// one average update on channel c, then the offset code is compared
	task automatic trk(input int c, input logic [11:0] a, input logic [5:0] e);
		avg1 = a;
		avg2 = ~a;
		if (c == 1) avg2 = a;
		avg_upd[c] = 1'b1;
		cyc(1);
		avg_upd = 2'b00;
		cyc(1);
		chk("offset code", c ? code2 : code1, e);
	endtask : trk

	// expected channel order is queued first; cont mode is stopped once drained
	task automatic run(input logic [2:0] op, input logic e1, input logic e2, input int n);
		en1 = e1;
		en2 = e2;
		for (int i = 0; i < n; i++) begin
			if (e1) exp_ch.push_back(1'b0);
			if (e2) exp_ch.push_back(1'b1);
		end
		u_cmoc_host_model.set_mode(op);
		for (int i = 0; i < 200 && exp_ch.size() != 0; i++) cyc(1);
		chk("starts left", exp_ch.size(), 0);
		if (op == 3'd2) begin
			cyc(8);
			chk("mode", mode, CMOC_MODE_IDLE);
		end
		u_cmoc_host_model.set_mode(3'd0);
		cyc(8);
	endtask : run

	// ----------------------------------------
	// monitor: pops the oldest note per result
	// ----------------------------------------
	always @(posedge clk) begin
		if (rd_d) chk("rdata", rdata, exp_rd.pop_front());
		if (rd_mark) chk("rhit", rhit, raddr inside {[8'h10:8'h12]});
		rd_d <= rd_mark;
		if (conv_start === 1'b1) begin
			if (exp_ch.size() == 0) chk("extra start", 12'd1, 12'd0);
			else chk("conv ch", conv_ch, exp_ch.pop_front());
		end
	end

	// converter stand-in: answers each start after one to three cycles
	initial forever begin
		@(posedge clk);
		if (conv_start === 1'b1) begin
			repeat (xs() % 3 + 1) @(posedge clk);
			#1 conv_done = 1'b1;
			@(posedge clk);
			#1 conv_done = 1'b0;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		fork
			begin
				#(4 * 20000);
				n_fail++;
				close_out();
			end
		join_none
		repeat (8) @(posedge clk);
		#1 reset_n = 1'b1;
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h00);
		rd(8'h12, 8'h00);
		u_cmoc_host_model.wr_reg(8'h11, 8'hC5);
		chk("code1", code1, 6'h05);
		r = xs();
		u_cmoc_host_model.wr_reg(8'h12, r[7:0]);
		u_cmoc_host_model.wr_reg(8'h13, 8'hFF);
		chk("code2", code2, r[5:0]);
		rd(8'h11, 8'hC5);
		rd(8'h12, r[7:0]);
		rd(8'h13, 8'h00);
		for (int m = 0; m < 4; m++) begin
			u_cmoc_host_model.set_mode(m[2:0]);
			chk("mode", mode, m[1:0]);
			chk("power", core_power, m != 3);
			chk("src en", src_en, (m != 3) ? {r[7], 1'b1} : 2'b00);
		end
		run(3'd2, 1'b1, 1'b1, 1);
		run(3'd2, 1'b0, 1'b1, 1);
		// both-channel run follows a channel two start, so it opens on channel one
		run(3'd1, 1'b1, 1'b1, 3);
		run(3'd1, 1'b1, 1'b0, 4);
		u_cmoc_host_model.wr_reg(8'h10, 8'hC3);
		cyc(8);
		chk("auto pd early", auto_pd, 0);
		for (int i = 0; i < 8 && auto_pd !== 1'b1; i++) cyc(1);
		chk("auto pd", auto_pd, 1);
		rd(8'h10, 8'h03);
		cmp = 2'b11;
		cyc(20);
		cmp = 2'b00;
		chk("auto mode", mode, CMOC_MODE_PDOWN);
		chk("power", core_power, 0);
		u_cmoc_host_model.wr_reg(8'h10, 8'h00);
		u_cmoc_host_model.set_mode(3'd0);
		chk("wake", auto_pd, 0);
		cyc(100);
		chk("no timer", auto_pd, 0);
		u_cmoc_host_model.wr_reg(8'h10, 8'h02);
		for (int i = 0; i < 8; i++) begin
			cyc(5);
			cmp = 2'(xs() % 3 + 1);
			cyc(1);
			cmp = 2'b00;
		end
		chk("activity", auto_pd, 0);
		u_cmoc_host_model.wr_reg(8'h10, 8'h00);
		for (int c = 0; c < 2; c++) begin
			step = 6'(xs() % 7 + 1);
			u_cmoc_host_model.wr_reg(8'(8'h11 + c), 8'hE0);
			chk("trk", trk_act[c], 1);
			// with the clock enable low an average update must not move the code
			ce = 1'b0;
			trk(c, 12'hFFF, 6'h20);
			ce = 1'b1;
			trk(c, 12'd3073 + 12'(xs() % 1000), 6'h20 + step);
			trk(c, 12'd3072, 6'h20 + step);
			trk(c, 12'd1024, 6'h20 + step);
			trk(c, 12'(xs() % 1024), 6'h20);
			u_cmoc_host_model.wr_reg(8'(8'h11 + c), 8'hFE);
			trk(c, 12'hFFF, 6'h3F);
			u_cmoc_host_model.wr_reg(8'(8'h11 + c), 8'hC0);
			trk(c, 12'h000, 6'h00);
			fixed_sel = 1'b1;
			cyc(1);
			chk("trk fixed", trk_act[c], 0);
			trk(c, 12'hFFF, 6'h00);
			fixed_sel = 1'b0;
			u_cmoc_host_model.wr_reg(8'(8'h11 + c), 8'h05);
			chk("src off", src_en[c], 0);
			trk(c, 12'hFFF, 6'h05);
		end
		close_out();
	end
endmodule : cmoc_mode_ctrl_bench
